//--- logic/baud_tick_gen.sv
/*
  baud-rate clock divider: one-cycle enable per divisor count of clk_sys.
  assumes the divisor is stable while the uart is enabled.
*/
`timescale 1ns/1ps
module baud_tick_gen (
  input  wire logic                      clk_sys,
  input  wire logic                      rstn,
  input  wire logic                      uartEnable,
  input  wire logic                      infrared_mode_enable,
  input  wire logic [15:0]               baud_divisor_value,
  input  wire logic                      txBitStart,
  baud_tick_if.source                    tick
);
  import irda_pkg::*;

  logic [15:0] divCount_reg;
  logic [15:0] divCount_next;
  logic [3:0]  phase_reg;
  logic        tickNow;
  logic        active;

  // ****************************************************************
  // divider
  // ****************************************************************
  assign active        = uartEnable & infrared_mode_enable;
  // a divisor of zero is treated as one so the tick never stalls
  assign tickNow       = active &
                         ((divCount_reg + 16'h0001) >= baud_divisor_value);
  assign divCount_next = tickNow ? 16'h0000 : divCount_reg + 16'h0001;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      divCount_reg <= 16'h0000;
      phase_reg    <= 4'h0;
    end else if (!active) begin
      divCount_reg <= 16'h0000;
      phase_reg    <= 4'h0;
    end else begin
      if (txBitStart) begin
        // restart the divider too, so the first bit is a full sixteen ticks
        divCount_reg <= 16'h0000;
        phase_reg    <= 4'h0;
      end else begin
        divCount_reg <= divCount_next;
        if (tickNow) begin
          phase_reg <= phase_reg + 4'h1;
        end
      end
    end
  end

  assign tick.baudTick    = tickNow;
  assign tick.endecActive = active;
  assign tick.phase       = phase_reg;
endmodule : baud_tick_gen

//--- logic/baud_tick_if.sv
/*
  interface carrying the baud-rate tick and enable between the endec parts.
  assumes all users share clk_sys.
*/
`timescale 1ns/1ps
interface baud_tick_if;
  logic       baudTick;
  logic       endecActive;
  logic [3:0] phase;
  modport source (output baudTick, output endecActive, output phase);
  modport sink   (input baudTick, input endecActive, input phase);
endinterface : baud_tick_if

//--- logic/infrared_endec.sv
/*
  infrared encoder/decoder between a uart and an infrared transceiver.
  assumes the uart supplies its serial transmit level, its enable and the
  divisor bytes; the receive pin is asynchronous and active-low pulsed.
*/
`timescale 1ns/1ps
module infrared_endec (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       uartEnable,
  input  wire logic       infrared_mode_enable,
  input  wire logic [7:0] divisorHigh,
  input  wire logic [7:0] divisorLow,
  input  wire logic       uartTxd,
  input  wire logic       irRxPin,
  output logic            txPin,
  output logic            infrared_pulse_output,
  output logic            uartRxd,
  output logic            rxBusy
);
  import irda_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  baud_tick_if  tick ();
  logic [15:0]  baud_divisor_value;
  logic         rxSync1_reg;
  logic         rxSync2_reg;
  logic         rxPrev_reg;
  logic         fallEdge;
  logic         txBit_reg;
  logic         txBusy_reg;
  logic         txPrevUart_reg;
  logic         txBitStart;
  logic         pulseNext;
  logic         pulse_reg;
  logic         rxdNext;
  logic         rxd_reg;
  logic [4:0]   decCount_reg;
  logic [4:0]   decCount_next;
  logic         windowExpired;
  logic         rxAllowed;
  decodeState_t decState_reg;
  decodeState_t decState_next;

  // ****************************************************************
  // divisor and tick
  // ****************************************************************
  // the two byte registers live in the uart and reset to all ones there
  assign baud_divisor_value = {divisorHigh, divisorLow};

  baud_tick_gen u_tick (
    .clk_sys              (clk_sys),
    .rstn                 (rstn),
    .uartEnable           (uartEnable),
    .infrared_mode_enable (infrared_mode_enable),
    .baud_divisor_value   (baud_divisor_value),
    .txBitStart           (txBitStart),
    .tick                 (tick)
  );

  // ****************************************************************
  // encoder
  // ****************************************************************
  // a txd edge while idle realigns the bit frame to the uart
  assign txBitStart = tick.endecActive & !txBusy_reg & (uartTxd != txPrevUart_reg);
  assign pulseNext  = tick.endecActive & !txBit_reg &
                      (tick.phase >= PULSE_START_TICK) &
                      (tick.phase <  PULSE_END_TICK);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      txBit_reg      <= 1'b1;
      txBusy_reg     <= 1'b0;
      txPrevUart_reg <= 1'b1;
      pulse_reg      <= 1'b0;
    end else begin
      txPrevUart_reg <= uartTxd;
      pulse_reg      <= pulseNext;
      if (txBitStart || (tick.baudTick && tick.phase == 4'hF)) begin
        txBit_reg <= uartTxd;
      end
      if (!tick.endecActive) begin
        txBusy_reg <= 1'b0;
      end else if (txBitStart) begin
        txBusy_reg <= 1'b1;
      end else if (tick.baudTick && tick.phase == 4'hF && uartTxd && txBit_reg) begin
        txBusy_reg <= 1'b0;
      end
    end
  end

  assign infrared_pulse_output = pulse_reg;
  // raw txd stays inside while infrared mode owns the pin
  assign txPin = infrared_mode_enable ? pulse_reg : uartTxd;

  // ****************************************************************
  // decoder input synchroniser
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rxSync1_reg <= 1'b1;
      rxSync2_reg <= 1'b1;
      rxPrev_reg  <= 1'b1;
    end else begin
      rxSync1_reg <= irRxPin;
      rxSync2_reg <= rxSync1_reg;
      rxPrev_reg  <= rxSync2_reg;
    end
  end

  // half duplex: the receiver is deaf while a frame is being sent
  assign rxAllowed = tick.endecActive & !txBusy_reg;
  assign fallEdge  = rxAllowed & rxPrev_reg & !rxSync2_reg;

  // ****************************************************************
  // decoder state machine
  // ****************************************************************
  assign windowExpired = (decCount_reg >= WINDOW_LIMIT);

  always_comb begin
    decState_next = decState_reg;
    decCount_next = decCount_reg;
    rxdNext       = rxd_reg;
    unique case (decState_reg)
      DEC_IDLE: begin
        rxdNext = 1'b1;
        if (fallEdge) begin
          decState_next = DEC_TRACK;
          decCount_next = 5'h00;
          rxdNext       = 1'b0;
        end
      end
      DEC_TRACK: begin
        if (fallEdge) begin
          decCount_next = 5'h00;
          rxdNext       = 1'b0;
        end else if (windowExpired) begin
          decState_next = DEC_IDLE;
          rxdNext       = 1'b1;
        end else if (tick.baudTick) begin
          decCount_next = decCount_reg + 5'h01;
          if (decCount_reg == 5'h0F) begin
            rxdNext = 1'b1;
          end
        end
      end
      DEC_OFF: begin
        rxdNext = 1'b1;
        if (rxAllowed) begin
          decState_next = DEC_IDLE;
        end
      end
      default: begin
        decState_next = DEC_IDLE;
        rxdNext       = 1'b1;
      end
    endcase
    if (!rxAllowed) begin
      decState_next = DEC_OFF;
      rxdNext       = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      decState_reg <= DEC_OFF;
      decCount_reg <= 5'h00;
      rxd_reg      <= 1'b1;
    end else begin
      decState_reg <= decState_next;
      decCount_reg <= decCount_next;
      rxd_reg      <= rxdNext;
    end
  end

  // only the bit level goes to the uart; its own start-bit logic resyncs it
  assign uartRxd = infrared_mode_enable ? rxd_reg : rxSync2_reg;
  assign rxBusy  = (decState_reg == DEC_TRACK);
endmodule : infrared_endec

//--- logic/irda_pkg.sv
/*
  constants and types shared by the infrared encoder/decoder files.
  assumes a single 20 MHz system clock and no software-visible registers.
*/
package irda_pkg;
  // ****************************************************************
  // bit timing in baud-rate clocks, divisor reset values and the clock rate
  // ****************************************************************
  localparam int unsigned BAUD_TICKS_PER_BIT = 16;
  localparam logic [3:0]  PULSE_START_TICK   = 4'h7;
  localparam logic [3:0]  PULSE_END_TICK     = 4'hA;
  localparam logic [4:0]  WINDOW_LATE_TICKS  = 5'h08;
  localparam logic [4:0]  WINDOW_LIMIT       = 5'h18;
  localparam logic [15:0] DIVISOR_RESET      = 16'hFFFF;
  localparam logic [7:0]  DIVISOR_BYTE_RESET = 8'hFF;
  localparam real         CLOCK_MHZ          = 20.0;

  // ****************************************************************
  // decoder states
  // ****************************************************************
  typedef enum logic [2:0] {
    DEC_IDLE  = 3'b001,
    DEC_TRACK = 3'b010,
    DEC_OFF   = 3'b100
  } decodeState_t;
endpackage : irda_pkg

//--- sim/infrared_endec_monitor.sv
/*
  port checker for the infrared endec.
  assumes it is bound onto infrared_endec.
*/
`timescale 1ns/1ps
module infrared_endec_monitor (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       uartEnable,
  input wire logic       infrared_mode_enable,
  input wire logic [7:0] divisorHigh,
  input wire logic [7:0] divisorLow,
  input wire logic       uartTxd,
  input wire logic       irRxPin,
  input wire logic       txPin,
  input wire logic       infrared_pulse_output,
  input wire logic       uartRxd,
  input wire logic       rxBusy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ****
  // run lengths in clocks
  // ****
  logic [21:0] div, hiRun_reg, txHi_reg, sinceFall_reg;
  logic        rxLast_reg;
  assign div = ({divisorHigh, divisorLow} == 16'h0000) ? 22'h00_0001 :
               22'({divisorHigh, divisorLow});
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hiRun_reg <= '0;
      txHi_reg <= '0;
      sinceFall_reg <= '0;
      rxLast_reg <= 1'b1;
    end else begin
      hiRun_reg <= infrared_pulse_output ? hiRun_reg + 22'h00_0001 : '0;
      // txd high a whole bit and more means the encoder is idle
      txHi_reg <= uartTxd ? txHi_reg + 22'h00_0001 : '0;
      sinceFall_reg <= (rxLast_reg && !irRxPin) ? '0 : sinceFall_reg + 22'h00_0001;
      rxLast_reg <= irRxPin;
    end
  end
  sequence s_rxStart;
    infrared_mode_enable && uartEnable && !rxBusy && txHi_reg > 16 * div + 2 ##1 $fell(irRxPin);
  endsequence
  property p_mux; txPin == (infrared_mode_enable ? infrared_pulse_output : uartTxd); endproperty
  a_mux: assert property (p_mux) else $error("tx pin select wrong");
  property p_inert; !uartEnable [*2] |-> !infrared_pulse_output && !rxBusy; endproperty
  a_inert: assert property (p_inert) else $error("endec active while off");
  property p_width; $fell(infrared_pulse_output) |-> hiRun_reg == 3 * div; endproperty
  a_width: assert property (p_width) else $error("pulse width wrong");
  property p_duplex; infrared_pulse_output |-> !rxBusy; endproperty
  a_duplex: assert property (p_duplex) else $error("receive during transmit");
  property p_decode; s_rxStart |-> ##[1:4] !uartRxd; endproperty
  a_decode: assert property (p_decode) else $error("pulse not decoded");
  property p_idle; $fell(rxBusy) |-> uartRxd; endproperty
  a_idle: assert property (p_idle) else $error("idle bit not high");
  property p_window; rxBusy |-> sinceFall_reg <= 24 * div + 6; endproperty
  a_window: assert property (p_window) else $error("window too long");
  property p_raw; (!infrared_mode_enable && irRxPin) [*3] |-> uartRxd; endproperty
  a_raw: assert property (p_raw) else $error("raw receive lost");
endmodule : infrared_endec_monitor

bind infrared_endec infrared_endec_monitor mon (
  .clk_sys(clk_sys), .rstn(rstn), .uartEnable(uartEnable),
  .infrared_mode_enable(infrared_mode_enable), .divisorHigh(divisorHigh),
  .divisorLow(divisorLow), .uartTxd(uartTxd), .irRxPin(irRxPin), .txPin(txPin),
  .infrared_pulse_output(infrared_pulse_output), .uartRxd(uartRxd), .rxBusy(rxBusy)
);

//--- sim/ir_transceiver_model.sv
/*
  transceiver stand-in: emits active-low receive pulses, counts led flashes.
  assumes divisor 1 while a frame is sent.
*/
`timescale 1ns/1ps
module ir_transceiver_model (
  input  wire logic clk_sys,
  input  wire logic led,
  output logic      irRxPin,
  output int        flashes
);
  // ****
  // detector output has a pull-up: high between pulses
  // ****
  initial irRxPin = 1'b1;
  initial begin
    flashes = 0;
    forever @(posedge led) flashes++;
  end
  task automatic sendFrame(input logic [9:0] bits, input int skew);
    for (int i = 0; i < 10; i++) begin
      repeat (7) @(negedge clk_sys);
      irRxPin = bits[i]; // zero: 3-tick pulse after 7 ticks
      repeat (3) @(negedge clk_sys);
      irRxPin = 1'b1;
      repeat (6 + skew) @(negedge clk_sys);
    end
  endtask : sendFrame
endmodule : ir_transceiver_model

//--- sim/tb_infrared_endec.sv
/*
  self-checking bench for the infrared endec.
  assumes the transceiver model on the far side.
*/
`timescale 1ns/1ps
module tb_infrared_endec;
  import irda_pkg::*;
  logic       clk_sys, rstn, uartEnable, infrared_mode_enable, uartTxd;
  logic [7:0] divisorHigh, divisorLow;
  logic       irRxPin, txPin, infrared_pulse_output, uartRxd, rxBusy;
  int         flashes, n_fail, checks_done;
  infrared_endec dut (.clk_sys(clk_sys), .rstn(rstn), .uartEnable(uartEnable),
    .infrared_mode_enable(infrared_mode_enable), .divisorHigh(divisorHigh),
    .divisorLow(divisorLow), .uartTxd(uartTxd), .irRxPin(irRxPin), .txPin(txPin),
    .infrared_pulse_output(infrared_pulse_output), .uartRxd(uartRxd), .rxBusy(rxBusy));
  ir_transceiver_model partner (.clk_sys(clk_sys), .led(infrared_pulse_output),
    .irRxPin(irRxPin), .flashes(flashes));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_fail++;
    close_out();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic close_out();
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic sendTx(input logic [9:0] bits, input int n, input int div, input int gain);
    int hi, first, f0, busy, z;
    f0 = flashes;
    busy = 0;
    z = 0;
    for (int i = 0; i < n; i++) begin
      hi = 0;
      first = 0;
      z += !bits[i];
      @(negedge clk_sys);
      uartTxd = bits[i];
      for (int c = 1; c < BAUD_TICKS_PER_BIT * div; c++) begin
        @(negedge clk_sys);
        busy |= (rxBusy === 1'b1);
        if (infrared_pulse_output === 1'b1) begin
          if (hi == 0) first = c;
          hi++;
        end
      end
      check(hi, bits[i] ? 0 : 3 * div * gain);
      if (hi > 0) check(first >= 7 * div && first <= 8 * div + 2, 1);
      check(txPin, infrared_mode_enable ? infrared_pulse_output : uartTxd);
    end
    check(flashes - f0, z * gain);
    check(busy, 0);
  endtask : sendTx
  task automatic rxFrame(input logic [9:0] bits);
    fork
      partner.sendFrame(bits, 2); // two clocks slow each bit
      begin
        repeat (15) @(negedge clk_sys);
        for (int i = 0; i < 10; i++) begin
          if (i > 0) repeat (18) @(negedge clk_sys);
          check(uartRxd, bits[i]);
          if (i == 0) check(rxBusy, 1);
        end
      end
    join
    repeat (40) @(negedge clk_sys);
    check(rxBusy, 0);
  endtask : rxFrame
  initial begin
    rstn = 1'b0;
    uartEnable = 1'b0;
    infrared_mode_enable = 1'b1;
    uartTxd = 1'b1;
    divisorHigh = 8'hFF;
    divisorLow = 8'hFF;
    n_fail = 0;
    checks_done = 0;
    repeat (5) @(negedge clk_sys);
    check(uartRxd, 1);
    check(infrared_pulse_output, 0);
    rstn = 1'b1;
    divisorHigh = 8'h01;
    divisorLow = 8'h00;
    // mode is set before the uart starts, so no stray pulse
    uartEnable = 1'b1;
    sendTx(10'h002, 2, 256, 1);
    uartEnable = 1'b0;
    infrared_mode_enable = 1'b0;
    divisorHigh = 8'h00;
    divisorLow = 8'h01;
    sendTx({1'b1, 8'hA5, 1'b0}, 10, 1, 0);
    infrared_mode_enable = 1'b1;
    uartEnable = 1'b1;
    sendTx({1'b1, 8'hA5, 1'b0}, 10, 1, 1);
    repeat (40) @(negedge clk_sys);
    rxFrame({1'b1, 8'h9C, 1'b0});
    fork
      sendTx({1'b1, 8'h00, 1'b0}, 10, 1, 1);
      partner.sendFrame(10'h000, 0);
    join
    close_out();
  end
endmodule : tb_infrared_endec
